// ### rtl/hsscfg_top.sv
// strap capture at reset release and status reuse of the strap pins
// How it works
// - sample mode strap; 0 smbus, 1 i2c
// - strap 1 makes serial pins eeprom i2c
// - strap 0 makes serial pins smbus slave
// - sample polarity strap; 1 means active low
// - polarity pin later shows port 1 superspeed
// - mode pin later shows port 2 superspeed
// - sample gang strap; 1 means ganged power
// - smbus address bit 2 from gang strap
// - smbus address bit 3 always one
// - gang pin later shows upstream high speed
// - sample power strap; 0 means switching supported
// - switching supported drives per port power outputs
// - smbus address bit 1 from power strap
// - power pin later shows upstream superspeed
// - test pin high at reset enters test
// - ganged overcurrent reported as hub event
`timescale 1ns/1ps
module hsscfg_top
	import hsscfg_pkg::*;
#(
	parameter int SETTLE_CYCLES = 4  // cycles of pin settling before capture
) (
	input  wire logic       clk,                        // 250 MHz clock
	input  wire logic       rst_n,                      // async reset, low
	input  wire logic       serial_mode_select_n_in,    // mode strap pin in
	input  wire logic       power_ctl_polarity_strap_in,// polarity pin in
	input  wire logic       slave_addr_bit2_strap_in,   // gang pin in
	input  wire logic       slave_addr_bit1_strap_in,   // power strap pin in
	input  wire logic       test_in,                    // factory test pin
	input  wire logic       port1_overcurrent_in_n,     // port 1 fault, low
	input  wire logic       port2_overcurrent_in_n,     // port 2 fault, low
	input  wire logic [1:0] port_power_req,             // hub wants power
	input  wire logic [1:0] ds_superspeed,              // port ss links
	input  wire logic       us_highspeed,               // upstream hs link
	input  wire logic       us_superspeed,              // upstream ss link
	output logic            ds2_superspeed_status,      // mode pin out
	output logic            ds1_superspeed_status,      // polarity pin out
	output logic            upstream_highspeed_status,  // gang pin out
	output logic            upstream_superspeed_status, // power pin out
	output logic            status_pins_oe,             // strap pins driven
	output logic [1:0]      port_power_ctl_out,         // power switch ctl
	output logic            i2c_mode,                   // serial as eeprom
	output logic            smbus_slave_mode,           // serial as slave
	output logic [6:0]      smbus_slave_addr,           // slave address
	output logic            ganged_mode,                // ganged power
	output logic            power_switching_en,         // switching on
	output logic            test_mode,                  // factory test
	output logic            hub_overcurrent,            // hub level fault
	output logic [1:0]      port_overcurrent,           // per port fault
	output logic            straps_valid                // capture done
);
	localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
	localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);

	typedef struct packed {
		hsscfg_state_t   st;
		logic [CNT_W-1:0] cnt;
		logic            mode;
		logic            pol;
		logic            gang;
		logic            pwr_dis;
		logic            test;
		logic [3:0]      stat;
		logic            oe;
		logic [1:0]      pwr;
		logic            hub_oc;
		logic [1:0]      port_oc;
		logic            i2c;
		logic            smb;
		logic            psw;
	} hsscfg_reg_t;

	hsscfg_reg_t r_q, r_d;
	logic [6:0]  pin_s;
	logic [1:0]  oc_n;
	logic [1:0]  pwr_on;
	logic        any_oc;

	// -----------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------
	logic [6:0] pin_raw;
	assign pin_raw = {port2_overcurrent_in_n, port1_overcurrent_in_n,
		test_in, slave_addr_bit1_strap_in, slave_addr_bit2_strap_in,
		power_ctl_polarity_strap_in, serial_mode_select_n_in};
	for (genvar i = 0; i < 7; i++) begin : g_sync
		hsscfg_sync u_sync (
			.clk   (clk),
			.rst_n (rst_n),
			.d     (pin_raw[i]),
			.q     (pin_s[i])
		);
	end
	assign oc_n = pin_s[6:5];

	// -----------------------------------------------------------
	// next state
	// -----------------------------------------------------------
	always_comb begin
		r_d = r_q;
		any_oc = ~oc_n[0] | ~oc_n[1];   // either input serves when ganged
		pwr_on = '0;
		unique case (r_q.st)
			// straps float in while synchronisers fill
			HSSCFG_ST_HOLD: begin
				r_d.cnt = r_q.cnt + 1'b1;
				if (r_q.cnt == SETTLE_LAST)
					r_d.st = HSSCFG_ST_SAMPLE;
			end
			// one-shot capture after release
			HSSCFG_ST_SAMPLE: begin
				r_d.mode    = pin_s[0];
				r_d.pol     = pin_s[1];
				r_d.gang    = pin_s[2];
				r_d.pwr_dis = pin_s[3];
				r_d.test    = pin_s[4];
				r_d.st      = HSSCFG_ST_RUN;
			end
			// straps frozen until reset; pins become status
			HSSCFG_ST_RUN: begin
				r_d.oe   = 1'b1;
				// roles registered so every output leaves a flop
				r_d.i2c  = (r_q.mode == HSSCFG_I2C);
				r_d.smb  = (r_q.mode == HSSCFG_SMBUS);
				r_d.psw  = (r_q.pwr_dis == HSSCFG_PSW_OK);
				r_d.stat[0] = ds_superspeed[1];
				r_d.stat[1] = ds_superspeed[0];
				r_d.stat[2] = us_highspeed;
				r_d.stat[3] = us_superspeed;
				if (r_q.gang == HSSCFG_GANG_ON) begin
					r_d.hub_oc  = any_oc;
					r_d.port_oc = '0;
					// ganged: power all if any asked, none on fault
					pwr_on = (|port_power_req && !any_oc) ? 2'b11 : 2'b00;
				end else begin
					r_d.hub_oc  = 1'b0;
					r_d.port_oc = ~oc_n;
					pwr_on = port_power_req & oc_n;
				end
				if (r_q.pwr_dis != HSSCFG_PSW_OK)
					pwr_on = '0;
			end
			default: r_d.st = HSSCFG_ST_HOLD;
		endcase
		// polarity applied to the switch controls
		r_d.pwr = (r_q.pol == HSSCFG_POL_HIGH) ? pwr_on
			: ~pwr_on;
		if (r_q.st != HSSCFG_ST_RUN)
			r_d.pwr = (pin_s[1] == HSSCFG_POL_HIGH) ? 2'b00 : 2'b11;
	end

	// -----------------------------------------------------------
	// state register
	// -----------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			r_q <= '{st: HSSCFG_ST_HOLD, default: '0};
		else
			r_q <= r_d;
	end

	// -----------------------------------------------------------
	// outputs, all straight from flops
	// -----------------------------------------------------------
	assign ds2_superspeed_status      = r_q.stat[0];
	assign ds1_superspeed_status      = r_q.stat[1];
	assign upstream_highspeed_status  = r_q.stat[2];
	assign upstream_superspeed_status = r_q.stat[3];
	assign status_pins_oe             = r_q.oe;
	assign port_power_ctl_out         = r_q.pwr;
	assign i2c_mode         = r_q.i2c;
	assign smbus_slave_mode = r_q.smb;
	// bit 3 fixed high; bits 2 and 1 from straps (strap wins on bit 2)
	always_comb begin
		smbus_slave_addr = HSSCFG_ADDR_BASE;
		smbus_slave_addr[HSSCFG_ADDR_BIT2] = r_q.gang;
		smbus_slave_addr[HSSCFG_ADDR_BIT1] = r_q.pwr_dis;
	end
	assign ganged_mode        = r_q.gang;
	assign power_switching_en = r_q.psw;
	assign test_mode          = r_q.test;
	assign hub_overcurrent    = r_q.hub_oc;
	assign port_overcurrent   = r_q.port_oc;
	assign straps_valid       = r_q.oe;

	// -----------------------------------------------------------
	// checks
	// -----------------------------------------------------------
	property p_cap_mode;
		@(posedge clk) disable iff (!rst_n)
		r_q.st == HSSCFG_ST_SAMPLE |=> r_q.mode == $past(pin_s[0]);
	endproperty
	a_cap_mode: assert property (p_cap_mode)
		else $error("mode strap lost");
	property p_cap_pol;
		@(posedge clk) disable iff (!rst_n)
		r_q.st == HSSCFG_ST_SAMPLE |=> r_q.pol == $past(pin_s[1]);
	endproperty
	a_cap_pol: assert property (p_cap_pol)
		else $error("pol strap lost");
	property p_hold;
		@(posedge clk) disable iff (!rst_n)
		r_q.oe |=> $stable({r_q.mode, r_q.pol, r_q.gang, r_q.pwr_dis});
	endproperty
	a_hold: assert property (p_hold)
		else $error("strap changed");
	property p_ds2;
		@(posedge clk) disable iff (!rst_n)
		r_q.st == HSSCFG_ST_RUN ##1 r_q.st == HSSCFG_ST_RUN
		|-> ds2_superspeed_status == $past(ds_superspeed[1]);
	endproperty
	a_ds2: assert property (p_ds2)
		else $error("ds2 status wrong");
	property p_addr3;
		@(posedge clk) disable iff (!rst_n) smbus_slave_addr[HSSCFG_ADDR_BIT3];
	endproperty
	a_addr3: assert property (p_addr3)
		else $error("addr bit3 low");
	property p_nopwr;
		@(posedge clk) disable iff (!rst_n)
		r_q.oe && r_q.pwr_dis |=> port_power_ctl_out == {2{r_q.pol}};
	endproperty
	a_nopwr: assert property (p_nopwr)
		else $error("power w/o switch");
	property p_gang_oc;
		@(posedge clk) disable iff (!rst_n)
		r_q.st == HSSCFG_ST_RUN && r_q.gang && !oc_n[1]
		|=> hub_overcurrent && port_overcurrent == 2'b00;
	endproperty
	a_gang_oc: assert property (p_gang_oc)
		else $error("gang oc wrong");
	property p_oe_late;
		@(posedge clk) disable iff (!rst_n)
		$rose(status_pins_oe) |-> $past(r_q.st) == HSSCFG_ST_RUN;
	endproperty
	a_oe_late: assert property (p_oe_late)
		else $error("oe too early");
	// exactly one serial role once the straps are captured
	property p_mode_excl;
		@(posedge clk) disable iff (!rst_n)
		straps_valid |-> i2c_mode != smbus_slave_mode;
	endproperty
	a_mode_excl: assert property (p_mode_excl)
		else $error("serial role wrong");
	c_i2c:   cover property (@(posedge clk) $rose(i2c_mode));
	c_smbus: cover property (@(posedge clk) $rose(smbus_slave_mode));
	c_gang:  cover property (@(posedge clk) hub_overcurrent);
endmodule // hsscfg_top

// ### rtl/hsscfg_pkg.sv
// constants for the hub strap capture and status pin block
package hsscfg_pkg;
	// serial pin modes chosen by the mode strap
	typedef enum logic {HSSCFG_SMBUS = 1'b0, HSSCFG_I2C = 1'b1} hsscfg_mode_t;
	// strap capture sequencing
	typedef enum logic [1:0] {HSSCFG_ST_HOLD, HSSCFG_ST_SAMPLE,
		HSSCFG_ST_RUN} hsscfg_state_t;
	// slave address field
	localparam int          HSSCFG_ADDR_W      = 7;
	localparam int          HSSCFG_ADDR_BIT1   = 1;
	localparam int          HSSCFG_ADDR_BIT2   = 2;
	localparam int          HSSCFG_ADDR_BIT3   = 3;
	localparam logic [6:0]  HSSCFG_ADDR_BASE   = 7'h08;
	localparam logic        HSSCFG_POL_HIGH    = 1'b0;
	localparam logic        HSSCFG_GANG_ON     = 1'b1;
	localparam logic        HSSCFG_PSW_OK      = 1'b0;
	localparam int          HSSCFG_PORTS       = 2;
endpackage

// ### rtl/hsscfg_sync.sv
// two-flop synchroniser for one asynchronous pin level
`timescale 1ns/1ps
module hsscfg_sync (
	input  wire logic clk,    // system clock
	input  wire logic rst_n,  // async reset, active low
	input  wire logic d,      // asynchronous level
	output logic      q       // synchronised level
);
	logic s1_q;
	// -----------------------------------------------------------
	// first stage feeds only the second stage
	// -----------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			q    <= 1'b0;
		end else begin
			s1_q <= d;
			q    <= s1_q;
		end
	end
endmodule // hsscfg_sync

// ### testbench/hsscfg_board.sv
// board side model of the strap pins: drivers until the device enables the status pins, pulls after
`timescale 1ns/1ps
module hsscfg_board (
	input  wire logic [4:0] strap, // mode, pol, gang, pwr, test levels
	input  wire logic       oe,    // device now drives the status pins
	output logic      [4:0] pin    // level seen at the strap inputs
);
	// ----------------------------------------
	// pin levels
	// ----------------------------------------
	// once released only the pulls remain: mode pu, pol pd, gang pu,
	// pwr pu, test pd; differs from most straps so late changes show up
	assign pin = oe ? 5'h16 : strap;
endmodule // hsscfg_board

// ### testbench/test_hub_strap_sampling_status_pins.sv
// self-checking bench for the strap capture and status pin block
`timescale 1ns/1ps
module test_hub_strap_sampling_status_pins;
	import hsscfg_pkg::*;
	localparam int SETTLE = 3; // shortened settling keeps the run short
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [4:0]  strap = 5'h00;
	logic [4:0]  pin;
	logic [1:0]  oc_n = 2'h3;
	logic [1:0]  req = 2'h0;
	logic [1:0]  dss = 2'h0;
	logic        uhs = 1'b0;
	logic        uss = 1'b0;
	logic        ds2, ds1, uhs_o, uss_o, oe, i2c, smb;
	logic        gang, psw, tst, hub_oc, valid;
	logic [1:0]  pwr, poc;
	logic [6:0]  addr;
	logic [31:0] seed = 32'h54B1;
	int          failures = 0;
	int          num_checks = 0;
	int          exp_q[$];  // model results: power, us ss, us hs, ds2, ds1

	hsscfg_board hsscfg_board_inst (.strap(strap), .oe(oe), .pin(pin));
	hsscfg_top #(.SETTLE_CYCLES(SETTLE)) hsscfg_top_inst (
		.clk(clk), .rst_n(rst_n), .serial_mode_select_n_in(pin[4]),
		.power_ctl_polarity_strap_in(pin[3]),
		.slave_addr_bit2_strap_in(pin[2]), .slave_addr_bit1_strap_in(pin[1]),
		.test_in(pin[0]), .port1_overcurrent_in_n(oc_n[0]),
		.port2_overcurrent_in_n(oc_n[1]), .port_power_req(req),
		.ds_superspeed(dss), .us_highspeed(uhs), .us_superspeed(uss),
		.ds2_superspeed_status(ds2), .ds1_superspeed_status(ds1),
		.upstream_highspeed_status(uhs_o),
		.upstream_superspeed_status(uss_o), .status_pins_oe(oe),
		.port_power_ctl_out(pwr), .i2c_mode(i2c), .smbus_slave_mode(smb),
		.smbus_slave_addr(addr), .ganged_mode(gang),
		.power_switching_en(psw), .test_mode(tst), .hub_overcurrent(hub_oc),
		.port_overcurrent(poc), .straps_valid(valid));

	// ----------------------------------------
	// clock, random source, checking
	// ----------------------------------------
	always #2 clk = ~clk;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input string what, input logic [6:0] exp,
		input logic [6:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic close_out();
		if (failures == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// captured straps must match what was presented during reset
	task automatic chk_caps(input logic [4:0] s);
		logic [6:0] a;
		chk("i2c", 7'(s[4]), 7'(i2c));
		chk("smbus", 7'(!s[4]), 7'(smb));
		chk("ganged", 7'(s[2]), 7'(gang));
		chk("switching", 7'(!s[1]), 7'(psw));
		chk("test", 7'(s[0]), 7'(tst));
		a = HSSCFG_ADDR_BASE;
		a[HSSCFG_ADDR_BIT2] = s[2];
		a[HSSCFG_ADDR_BIT1] = s[1];
		chk("addr", a, addr);
	endtask

	// ----------------------------------------
	// main sequence: every strap combination
	// ----------------------------------------
	initial begin
		logic [4:0]  s;
		logic [31:0] r;
		logic [1:0]  f;
		logic [1:0]  on;
		int          n;
		int          e;
		for (int it = 0; it < 32; it++) begin
			@(negedge clk);
			rst_n = 1'b0;
			s = 5'(it);
			strap = s;
			r = xs();
			oc_n = r[1:0];
			f = ~r[1:0];
			repeat (4) @(negedge clk);
			chk("oe in reset", 7'h00, 7'(oe));
			rst_n = 1'b1;
			n = 0;
			while (valid !== 1'b1 && n < 50) begin
				@(negedge clk);
				n++;
			end
			chk("capture time", 7'(SETTLE + 2), 7'(n));
			chk("oe", 7'h01, 7'(oe));
			for (int c = 0; c < 20; c++) begin
				r = xs();
				req = r[1:0];
				dss = r[3:2];
				uhs = r[4];
				uss = r[5];
				// model: ganged powers all or none, faults cut power
				on = s[2] ? {2{(|req) && !(|f)}} : (req & ~f);
				if (s[1])
					on = 2'h0;
				exp_q.push_back(int'({on ^ {2{s[3]}}, uss, uhs, dss}));
				@(negedge clk);
				e = exp_q.pop_front();
				chk("ds1", 7'(e[0]), 7'(ds1));
				chk("ds2", 7'(e[1]), 7'(ds2));
				chk("us hs", 7'(e[2]), 7'(uhs_o));
				chk("us ss", 7'(e[3]), 7'(uss_o));
				chk("power", 7'(e[5:4]), 7'(pwr));
				if (!s[1]) begin
					chk("hub oc", 7'(s[2] & (|f)), 7'(hub_oc));
					chk("port oc", 7'(s[2] ? 2'h0 : f), 7'(poc));
				end
				chk_caps(s);
			end
		end
		close_out();
	end

	// hang guard: about three times the expected run
	initial begin
		#12000;
		failures++;
		close_out();
	end
endmodule // test_hub_strap_sampling_status_pins
